// file: logic/mpag_access_gate.sv
// mpag_access_gate: two-level password gate for register writes.
// assumes requests come from the protocol engine on the same clock,
// one per cycle at most, already split into 16-bit register words.
`default_nettype none
module mpag_access_gate #(
  parameter int TICK_CYCLES = mpag_pkg::CLK_HZ,
  parameter logic [mpag_pkg::TMR_W-1:0] TIMEOUT_TICKS =
    mpag_pkg::TMR_W'(mpag_pkg::TIMEOUT_SEC)
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire mpag_pkg::mpag_req_type req,
  input wire logic [mpag_pkg::NCONN-1:0] connClose,
  input wire logic panelWr,
  input wire logic panelSelCfg,
  input wire logic [31:0] panelData,
  output mpag_pkg::mpag_rsp_type rsp,
  output logic [mpag_pkg::NCONN-1:0] opGranted,
  output logic [mpag_pkg::NCONN-1:0] cfgGranted,
  output logic opProtOn,
  output logic cfgProtOn
);
  import mpag_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic inPair(input logic [15:0] a,
                                  input logic [15:0] base);
    inPair = (a[15:1] == base[15:1]);
  endfunction

  function automatic logic [31:0] scramble(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ ENC_KEY;
    // zero stays zero so software sees "no password"
    scramble = (v == PW_NONE) ? PW_NONE
             : ((x << ENC_ROT) | (x >> (32 - ENC_ROT)));
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] opPw_r;
  logic [31:0] cfgPw_r;
  logic [15:0] hiWord_r [NCONN];
  logic [SEC_W-1:0] secCnt_r;
  logic secTick;
  logic [NCONN-1:0] opGrant_r;
  logic [NCONN-1:0] cfgGrant_r;
  mpag_rsp_type rsp_r;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic isWr, isLo, opOk, cfgOk;
  logic wrOpPw, wrCfgPw, wrOpEnt, wrCfgEnt, cmdWr, setWr;
  logic needOp, needCfg, allow;
  logic [31:0] fullWord;

  assign opProtOn = (opPw_r != PW_NONE);
  assign cfgProtOn = (cfgPw_r != PW_NONE);
  assign isWr = req.valid && (req.kind == MPAG_WRITE);
  assign isLo = req.addr[0];
  assign fullWord = {hiWord_r[req.conn], req.data};
  // protection off means every connection is treated as granted
  assign opOk = !opProtOn || opGrant_r[req.conn];
  assign cfgOk = !cfgProtOn || cfgGrant_r[req.conn];
  assign wrOpPw = isWr && inPair(req.addr, ADDR_OP_PW);
  assign wrCfgPw = isWr && inPair(req.addr, ADDR_CFG_PW);
  assign wrOpEnt = isWr && inPair(req.addr, ADDR_OP_ENT);
  assign wrCfgEnt = isWr && inPair(req.addr, ADDR_CFG_ENT);
  assign cmdWr = (isWr && req.addr >= CMD_LO && req.addr <= CMD_HI)
              || (req.valid && req.kind == MPAG_COIL);
  assign setWr = (isWr && req.addr >= SETTINGS_LO && !wrOpPw
                  && !wrOpEnt && !wrCfgEnt)
              || (req.valid && req.kind == MPAG_FWDL);
  assign needOp = wrOpPw || cmdWr;
  assign needCfg = setWr;
  assign allow = (!needOp || opOk)
              && (!needCfg || cfgOk);

  // ----------------------------------------------------------------
  // shared password settings
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      opPw_r <= PW_NONE;
    end else if (wrOpPw && isLo && allow) begin
      opPw_r <= fullWord;
    end else if (panelWr && !panelSelCfg) begin
      opPw_r <= panelData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfgPw_r <= PW_NONE;
    end else if (wrCfgPw && isLo && allow) begin
      cfgPw_r <= fullWord;
    end else if (panelWr && panelSelCfg) begin
      cfgPw_r <= panelData;
    end
  end

  // ----------------------------------------------------------------
  // upper-word latch, one per connection
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NCONN; i++) hiWord_r[i] <= 16'h0000;
    end else if (isWr && !isLo) begin
      hiWord_r[req.conn] <= req.data;
    end
  end

  // ----------------------------------------------------------------
  // one-second prescaler
  // ----------------------------------------------------------------
  // counting seconds keeps the per-link timers narrow
  assign secTick = (secCnt_r == SEC_W'(TICK_CYCLES - 1));
  always_ff @(posedge ref_clk) begin
    if (sys_rst || secTick) begin
      secCnt_r <= '0;
    end else begin
      secCnt_r <= secCnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // per-connection grants and timers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCONN; g++) begin : gConn
    logic [TMR_W-1:0] opTmr_r;
    logic [TMR_W-1:0] cfgTmr_r;
    logic mine, opEnt, cfgEnt, opUse, cfgUse;
    assign mine = (req.conn == CONN_W'(g));
    assign opEnt = mine && wrOpEnt && isLo;
    assign cfgEnt = mine && wrCfgEnt && isLo;
    assign opUse = mine && allow && needOp;
    assign cfgUse = mine && allow && needCfg;

    always_ff @(posedge ref_clk) begin
      if (sys_rst || connClose[g]) begin
        opGrant_r[g] <= 1'b0;
      end else if (opEnt) begin
        opGrant_r[g] <= (fullWord == opPw_r);
      // a use in the expiry cycle restarts the timer, so the grant stays
      end else if (secTick && !opUse
                   && opTmr_r >= TIMEOUT_TICKS - 1'b1) begin
        opGrant_r[g] <= 1'b0;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (sys_rst || connClose[g]) begin
        cfgGrant_r[g] <= 1'b0;
      end else if (cfgEnt) begin
        cfgGrant_r[g] <= (fullWord == cfgPw_r);
      end else if (secTick && !cfgUse
                   && cfgTmr_r >= TIMEOUT_TICKS - 1'b1) begin
        cfgGrant_r[g] <= 1'b0;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (sys_rst || opEnt || opUse) begin
        opTmr_r <= '0;
      end else if (secTick && opGrant_r[g]) begin
        opTmr_r <= opTmr_r + 1'b1;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (sys_rst || cfgEnt || cfgUse) begin
        cfgTmr_r <= '0;
      end else if (secTick && cfgGrant_r[g]) begin
        cfgTmr_r <= cfgTmr_r + 1'b1;
      end
    end
  end

  assign opGranted = opGrant_r;
  assign cfgGranted = cfgGrant_r;

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  logic [31:0] opEnc, cfgEnc;
  logic [15:0] rdData;
  logic rdOwn;
  assign opEnc = scramble(opPw_r);
  assign cfgEnc = scramble(cfgPw_r);

  always_comb begin
    rdData = 16'h0000;
    rdOwn = 1'b1;
    if (inPair(req.addr, ADDR_OP_PW)) begin
      rdData = isLo ? opEnc[15:0] : opEnc[31:16];
    end else if (inPair(req.addr, ADDR_CFG_PW)) begin
      rdData = isLo ? cfgEnc[15:0] : cfgEnc[31:16];
    end else if (req.addr == ADDR_OP_STAT) begin
      rdData = {15'h0000, opProtOn};
    end else if (req.addr == ADDR_CFG_STAT) begin
      rdData = {15'h0000, cfgProtOn};
    end else if (inPair(req.addr, ADDR_OP_ENT)
              || inPair(req.addr, ADDR_CFG_ENT)) begin
      rdData = 16'h0000; // entry registers are write-only
    end else begin
      rdOwn = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.valid <= req.valid;
      rsp_r.allow <= allow;
      rsp_r.own <= (req.kind == MPAG_READ) ? rdOwn
                 : (wrOpPw || wrCfgPw || wrOpEnt || wrCfgEnt);
      rsp_r.func <= allow ? req.func : (req.func | EXC_FLAG);
      rsp_r.excCode <= allow ? EXC_NONE : EXC_CODE;
      rsp_r.data <= (req.kind == MPAG_READ) ? rdData : req.data;
    end
  end

  assign rsp = rsp_r;
endmodule // mpag_access_gate
`default_nettype wire

// file: logic/mpag_pkg.sv
// mpag_pkg: constants and carrier types of the password access gate.
// assumes one system clock at 50 MHz and 16-bit register words.
`default_nettype none
package mpag_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_OP_PW = 16'h4000;
  localparam logic [15:0] ADDR_CFG_PW = 16'h4002;
  localparam logic [15:0] ADDR_OP_ENT = 16'h4008;
  localparam logic [15:0] ADDR_CFG_ENT = 16'h400A;
  localparam logic [15:0] ADDR_OP_STAT = 16'h4010;
  localparam logic [15:0] ADDR_CFG_STAT = 16'h4011;
  localparam logic [15:0] SETTINGS_LO = 16'h4000;
  localparam logic [15:0] CMD_LO = 16'h0280;
  localparam logic [15:0] CMD_HI = 16'h02FF;
  localparam logic [31:0] PW_NONE = 32'h0000_0000;
  // readback scramble key; arbitrary value
  localparam logic [31:0] ENC_KEY = 32'h5A3C_96E1;
  localparam int ENC_ROT = 7;
  // ----------------------------------------------------------------
  // answer codes
  // ----------------------------------------------------------------
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_CODE = 8'h03;
  localparam logic [7:0] EXC_NONE = 8'h00;
  // ----------------------------------------------------------------
  // connections and timing
  // ----------------------------------------------------------------
  localparam int NCONN = 4;
  localparam int CONN_W = 2;
  localparam int CLK_HZ = 50_000_000;
  localparam int TIMEOUT_MIN = 30;
  localparam int TIMEOUT_SEC = TIMEOUT_MIN * 60;
  localparam int SEC_W = 26;
  localparam int TMR_W = 11;

  typedef enum logic [1:0] {
    MPAG_READ = 2'b00,
    MPAG_WRITE = 2'b01,
    MPAG_COIL = 2'b10,
    MPAG_FWDL = 2'b11
  } mpag_kind_type;

  typedef struct packed {
    logic valid;
    logic [CONN_W-1:0] conn;
    mpag_kind_type kind;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] data;
  } mpag_req_type;

  typedef struct packed {
    logic valid;
    logic allow;
    logic own;
    logic [7:0] func;
    logic [7:0] excCode;
    logic [15:0] data;
  } mpag_rsp_type;
endpackage
`default_nettype wire

// file: sim/mpag_access_gate_chk.sv
// mpag_access_gate_chk: port assertions for the access gate.
// assumes the gate's top ports only; attached by bind below.
`default_nettype none
module mpag_access_gate_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire mpag_pkg::mpag_req_type req,
  input wire logic [mpag_pkg::NCONN-1:0] connClose,
  input wire mpag_pkg::mpag_rsp_type rsp,
  input wire logic [mpag_pkg::NCONN-1:0] opGranted,
  input wire logic [mpag_pkg::NCONN-1:0] cfgGranted,
  input wire logic opProtOn,
  input wire logic cfgProtOn
);
  import mpag_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic rd, ent1;
  assign rd = req.valid && req.kind == MPAG_READ;
  assign ent1 = req.valid && req.kind == MPAG_WRITE && req.conn == 2'h1
    && req.addr == ADDR_OP_ENT + 16'h1;
  sequence s_open_pw_read;
    rd && req.addr == ADDR_OP_PW && !opProtOn;
  endsequence
  a_refuse_flags: assert property (
    rsp.valid && !rsp.allow |-> rsp.func[7] && rsp.excCode == EXC_CODE)
    else $error("refusal without flag");
  a_answer_next: assert property (
    req.valid |=> rsp.valid && rsp.func[6:0] == $past(req.func[6:0]))
    else $error("answer missing");
  a_op_stat: assert property (
    rd && req.addr == ADDR_OP_STAT |=> rsp.data[0] == $past(opProtOn))
    else $error("op status wrong");
  a_cfg_stat: assert property (
    rd && req.addr == ADDR_CFG_STAT |=> rsp.data[0] == $past(cfgProtOn))
    else $error("cfg status wrong");
  a_close_drops: assert property (
    |connClose |=> ((opGranted | cfgGranted) & $past(connClose)) == '0)
    else $error("grant kept on close");
  a_coil_guard: assert property (
    req.valid && req.kind == MPAG_COIL && opProtOn
    && !opGranted[req.conn] |=> !rsp.allow) else $error("coil let in");
  a_grant_cause: assert property (
    $rose(opGranted[1]) |-> $past(ent1)) else $error("grant uncaused");
  a_pw_zero_read: assert property (
    s_open_pw_read |=> rsp.data == 16'h0000) else $error("pw read");
endmodule // mpag_access_gate_chk
bind mpag_access_gate mpag_access_gate_chk i_chk (.ref_clk, .sys_rst,
  .req, .connClose, .rsp, .opGranted, .cfgGranted, .opProtOn, .cfgProtOn);
`default_nettype wire

// file: sim/mpag_access_gate_tb_top.sv
// mpag_access_gate_tb_top: self-checking bench with a word model.
// assumes the gate with short timer parameters and the master model.
`default_nettype none
module mpag_access_gate_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mpag_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, panelWr = 1'b0, panelSelCfg = 1'b0;
  logic [31:0] panelData = 32'h0;
  logic [3:0] connClose = 4'h0, opGranted, cfgGranted;
  logic opProtOn, cfgProtOn;
  mpag_req_type req;
  mpag_rsp_type rsp;
  int badCount = 0, samplesChecked = 0;
  logic [31:0] pw [2];
  logic [3:0] gr [2];
  logic [15:0] hiW [4];
  always #10 ref_clk = ~ref_clk;
  mpag_master_model i_mst (.ref_clk, .req, .rsp);
  mpag_access_gate #(.TICK_CYCLES(4), .TIMEOUT_TICKS(11'h3)) i_dut (
    .ref_clk, .sys_rst, .req, .connClose, .panelWr, .panelSelCfg,
    .panelData, .rsp, .opGranted, .cfgGranted, .opProtOn, .cfgProtOn);
  // ----------------------------------------------------------------
  // model and checks
  // ----------------------------------------------------------------
  // answer fields, looked at while the one-cycle answer stands
  task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
    samplesChecked++;
    if (g !== e) begin
      badCount++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  // standing levels: grants and protection flags
  task automatic cmpLvl(string n, logic [15:0] e, logic [15:0] g);
    samplesChecked++;
    if (g !== e) begin
      badCount++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic logic [31:0] scr(logic [31:0] p);
    logic [31:0] x;
    x = p ^ ENC_KEY;
    return p == 0 ? 32'h0 : (x << ENC_ROT) | (x >> (32 - ENC_ROT));
  endfunction
  task automatic op(int c, mpag_kind_type k, logic [15:0] a,
                    logic [15:0] d = 16'h0);
    mpag_rsp_type r;
    logic [7:0] f;
    bit on, cn, al, en, ow;
    en = a[15:2] == 14'h1002;
    on = k == MPAG_COIL || k == MPAG_WRITE &&
      (a[15:1] == 15'h2000 || a inside {[CMD_LO:CMD_HI]});
    cn = k == MPAG_FWDL || k == MPAG_WRITE && a >= SETTINGS_LO && !on && !en;
    al = !(on && pw[0] != 0 && !gr[0][c]) && !(cn && pw[1] != 0 && !gr[1][c]);
    ow = (k == MPAG_READ || k == MPAG_WRITE) && (a[15:2] == 14'h1000
      || en || k == MPAG_READ && a[15:1] == 15'h2008);
    f = 8'h03 + 8'(k);
    i_mst.xfer(2'(c), k, a, d, r);
    cmp("allow", 16'(al), 16'(r.allow));
    cmp("func", {8'h0, al ? f : f | EXC_FLAG}, {8'h0, r.func});
    cmp("exc", {8'h0, al ? EXC_NONE : EXC_CODE},
      {8'h0, r.excCode});
    cmp("own", 16'(ow), 16'(r.own));
    if (k != MPAG_READ) cmp("echo", d, r.data);
    // the gate latches the upper word of every even write on the link
    if (k == MPAG_WRITE && !a[0]) hiW[c] = d;
    if (al && k == MPAG_WRITE && a[15:4] == 12'h400 && a[0]) begin
      if (a[3]) gr[a[1]][c] = {hiW[c], d} == pw[a[1]];
      else pw[a[1]] = {hiW[c], d};
    end
    if (k == MPAG_READ && a[15:5] == 11'h200)
      cmp("data", a[4] ? 16'(pw[a[0]] != 0) : en ? 16'h0 :
        16'(scr(pw[a[1]]) >> {~a[0], 4'h0}), r.data);
    cmpLvl("opGr", 16'(gr[0]), 16'(opGranted));
    cmpLvl("cfgGr", 16'(gr[1]), 16'(cfgGranted));
    cmpLvl("opOn", 16'(pw[0] != 0), 16'(opProtOn));
    cmpLvl("cfgOn", 16'(pw[1] != 0), 16'(cfgProtOn));
  endtask
  task automatic enter(int c, bit cf, logic [31:0] v);
    op(c, MPAG_WRITE, i_mst.entAddr(cf), v[31:16]);
    op(c, MPAG_WRITE, i_mst.entAddr(cf) + 16'h1, v[15:0]);
  endtask
  task automatic idle(int n, bit cf);
    repeat (n) @(negedge ref_clk);
    gr[cf] = 4'h0;
  endtask
  task automatic wrapUp;
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge ref_clk);
    badCount++;
    wrapUp();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v, u;
    void'($urandom(32'h74ED));
    pw = '{default: 32'h0};
    gr = '{default: 4'h0};
    hiW = '{default: 16'h0};
    v = $urandom | 32'h1;
    u = $urandom | 32'h1;
    repeat (5) @(negedge ref_clk);
    sys_rst = 1'b0;
    op(0, MPAG_READ, ADDR_OP_STAT);
    op(0, MPAG_READ, ADDR_CFG_STAT);
    op(2, MPAG_READ, ADDR_OP_PW);
    op(3, MPAG_COIL, 16'h0001);
    op(0, MPAG_WRITE, ADDR_OP_PW, v[31:16]);
    op(0, MPAG_WRITE, ADDR_OP_PW + 16'h1, v[15:0]);
    op(0, MPAG_READ, ADDR_OP_PW);
    op(0, MPAG_READ, ADDR_OP_PW + 16'h1);
    op(0, MPAG_READ, ADDR_OP_STAT);
    op(1, MPAG_WRITE, ADDR_OP_PW, 16'h0001);
    op(1, MPAG_WRITE, CMD_HI, 16'h0001);
    enter(1, 1'b0, v);
    op(1, MPAG_COIL, 16'h0002);
    op(2, MPAG_COIL, 16'h0002);
    enter(1, 1'b0, ~v);
    op(1, MPAG_COIL, 16'h0002);
    $display("test operate done");
    @(negedge ref_clk);
    panelWr = 1'b1;
    panelSelCfg = 1'b1;
    panelData = u;
    @(negedge ref_clk);
    panelWr = 1'b0;
    panelData = ~u;
    pw[1] = u;
    op(0, MPAG_READ, ADDR_CFG_STAT);
    op(0, MPAG_READ, ADDR_CFG_PW + 16'h1);
    op(0, MPAG_FWDL, 16'h0000);
    op(0, MPAG_WRITE, 16'h4051, 16'h00C8);
    enter(0, 1'b1, u);
    op(0, MPAG_FWDL, 16'h0000);
    op(0, MPAG_WRITE, 16'h4051, 16'h00C8);
    op(2, MPAG_WRITE, ADDR_CFG_PW, 16'h0001);
    idle(24, 1'b1);
    $display("test configure done");
    enter(1, 1'b0, v);
    repeat (10) op(1, MPAG_COIL, 16'h0003);
    idle(24, 1'b0);
    op(1, MPAG_COIL, 16'h0003);
    $display("test timer done");
    enter(1, 1'b0, v);
    connClose = 4'h2;
    idle(1, 1'b0);
    connClose = 4'h0;
    op(1, MPAG_COIL, 16'h0004);
    $display("test close done");
    // mid-run reset: stored passwords and grants must fall back to zero
    @(negedge ref_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    pw = '{default: 32'h0};
    gr = '{default: 4'h0};
    hiW = '{default: 16'h0};
    op(0, MPAG_READ, ADDR_OP_STAT);
    op(0, MPAG_READ, ADDR_CFG_PW);
    op(2, MPAG_COIL, 16'h0005);
    $display("test reset done");
    wrapUp();
  end
endmodule // mpag_access_gate_tb_top
`default_nettype wire

// file: sim/mpag_master_model.sv
// mpag_master_model: bus master issuing one request per call.
// assumes the gate answers on the edge after it takes a request.
`default_nettype none
module mpag_master_model (
  input wire logic ref_clk,
  output var mpag_pkg::mpag_req_type req,
  input wire mpag_pkg::mpag_rsp_type rsp
);
  import mpag_pkg::*;
  initial req = '0;
  function automatic logic [15:0] entAddr(bit cfg);
    return cfg ? ADDR_CFG_ENT : ADDR_OP_ENT;
  endfunction
  task automatic xfer(logic [1:0] c, mpag_kind_type k, logic [15:0] a,
                      logic [15:0] d, output mpag_rsp_type r);
    @(negedge ref_clk);
    req = '{1'b1, c, k, 8'h03 + 8'(k), a, d};
    @(negedge ref_clk);
    r = rsp;
    // released address and data lines show the inverse, not a stale value
    req = '{1'b0, c, k, 8'h00, ~a, ~d};
  endtask
endmodule // mpag_master_model
`default_nettype wire
